// ### daisy_chain_pwm_sink_driver_tb.sv
// Purpose: self-checking bench for the chained pwm sink driver
// Assumes: PWM_DIV of 4, so one pwm period is 1024 reference cycles
// Notes: on-times counted over a full period, independent of phase
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("BAD %s exp %0h got %0h", nm, exp, got); end end
module daisy_chain_pwm_sink_driver_tb;
	import dcp_pkg::*;
	localparam int DIV = 4;
	localparam logic [63:0] FR_A = 64'h00FF80017F400210;
	localparam logic [63:0] FR_B = 64'h1002407F0180FF00;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic en = 1'b1;
	int mismatches = 0;
	int n_checks = 0;
	wire logic sdat, sclk, sync, dat_out, clk_out, sync_out, en_out;
	wire logic [7:0] chan_on;
	dcp_pkg::dcp_state_t state;
	always #25 ref_clk_i = ~ref_clk_i;
	dcp_ctrl_model i_ctrl (.ref_clk_i(ref_clk_i), .data_o(sdat), .sclk_o(sclk), .sync_o(sync));
	dcp_driver #(.CHANNELS(8), .PWM_DIV(DIV)) i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.serial_data_in_i(sdat), .shift_clock_in_i(sclk), .sync_chain_in_i(sync),
		.global_enable_in_i(en), .serial_data_out_o(dat_out), .shift_clock_out_o(clk_out),
		.sync_chain_out_o(sync_out), .global_enable_out_o(en_out), .chan_on_o(chan_on),
		.state_o(state));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// on-count per channel over exactly one period equals duty times divider
	task automatic chk_duty(input logic [63:0] fr, input logic on);
		int cnt [8] = '{default: 0};
		repeat (256 * DIV) begin
			@(negedge ref_clk_i);
			for (int c = 0; c < 8; c++) if (chan_on[c] === 1'b1) cnt[c]++;
		end
		for (int c = 0; c < 8; c++) `CHK("duty", on ? int'(fr[63-8*c -: 8]) * DIV : 0, cnt[c])
	endtask
	task automatic t_frame(input logic [63:0] fr);
		fork
			i_ctrl.send(fr, 1'b1);
			begin
				repeat (300) @(negedge ref_clk_i);
				`CHK("sync_out_mid", 1'b0, sync_out)
				`CHK("state_mid", DCP_CAPTURE, state)
				@(posedge sclk);
				repeat (6) @(negedge ref_clk_i);
				`CHK("clk_buf_high", 1'b1, clk_out)
			end
		join
		repeat (8) @(negedge ref_clk_i);
		`CHK("sync_out_done", 1'b1, sync_out)
		`CHK("state_done", DCP_IDLE, state)
		`CHK("data_buf", sdat, dat_out)
		`CHK("clk_buf", 1'b0, clk_out)
		chk_duty(fr, 1'b1);
		i_ctrl.end_frame();
		repeat (8) @(negedge ref_clk_i);
		`CHK("sync_out_low", 1'b0, sync_out)
		$display("test frame done");
	endtask
	// bits with no sync rise must leave the old duties alone
	task automatic t_nosync(input logic [63:0] old);
		i_ctrl.send(~old, 1'b0);
		repeat (8) @(negedge ref_clk_i);
		`CHK("state_nosync", DCP_IDLE, state)
		chk_duty(old, 1'b1);
		$display("test nosync done");
	endtask
	task automatic t_disable(input logic [63:0] fr);
		en = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		`CHK("en_buf_low", 1'b0, en_out)
		chk_duty(fr, 1'b0);
		en = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		`CHK("en_buf_high", 1'b1, en_out)
		$display("test disable done");
	endtask
	// reset held 8 cycles: outputs forced on, no capture with sync pin low
	task automatic t_reset();
		repeat (8) @(negedge ref_clk_i);
		`CHK("reset_on", 8'hFF, chan_on)
		`CHK("reset_sync", 1'b0, sync_out)
		rst_n_i = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		`CHK("reset_state", DCP_IDLE, state)
		$display("test reset done");
	endtask
	initial begin
		t_reset();
		t_frame(FR_A);
		t_frame(FR_B);
		t_nosync(FR_B);
		t_disable(FR_B);
		print_verdict();
	end
	// watchdog well beyond the roughly 5700 cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		mismatches++;
		print_verdict();
	end
endmodule // daisy_chain_pwm_sink_driver_tb
`default_nettype wire

// ### dcp_ctrl_model.sv
// Purpose: behavioural dimming controller driving the chained link
// Assumes: tasks are entered just after a falling edge of ref_clk_i
// Notes: shift clock stands low between frames; released data shows the inverse
`timescale 1ns/100ps
`default_nettype none
module dcp_ctrl_model (
	input wire logic ref_clk_i,
	output logic data_o,
	output logic sclk_o,
	output logic sync_o
);
	initial begin
		data_o = 1'b0;
		sclk_o = 1'b0;
		sync_o = 1'b0;
	end
	// sync rise marks frame start, then 64 bits at 400 ns per bit
	task automatic send(input logic [63:0] frame, input logic with_sync);
		sync_o = with_sync;
		repeat (8) @(negedge ref_clk_i);
		for (int i = 63; i >= 0; i--) begin
			data_o = frame[i];
			repeat (4) @(negedge ref_clk_i);
			sclk_o = 1'b1;
			repeat (4) @(negedge ref_clk_i);
			sclk_o = 1'b0;
		end
		// inverse of the last bit, so a stale value cannot pass
		data_o = ~data_o;
	endtask
	task automatic end_frame();
		sync_o = 1'b0;
	endtask
endmodule // dcp_ctrl_model
`default_nettype wire

// ### dcp_defines.svh
// Purpose: timing constants and field sizes for the chained pwm sink driver
// Assumes: 20 MHz reference clock
// Notes: counts derived from times by expression
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH
`define DCP_REF_CLK_HZ 20000000
`define DCP_PWM_CLK_HZ 5000000
`define DCP_MIN_PULSE_NS 120
// reference cycles per pwm tick, at least one
`define DCP_PWM_DIV ((`DCP_REF_CLK_HZ / `DCP_PWM_CLK_HZ) < 1 ? 1 : (`DCP_REF_CLK_HZ / `DCP_PWM_CLK_HZ))
// shortest on-pulse in reference cycles, rounded up
`define DCP_MIN_PULSE_CYC ((`DCP_MIN_PULSE_NS * (`DCP_REF_CLK_HZ / 1000000) + 999) / 1000)
`define DCP_CHANNELS 8
`define DCP_BYTE_BITS 8
`endif

// ### dcp_driver.sv
// Purpose: eight channel 8-bit pwm sink driver with daisy-chained serial load
// Assumes: link pins asynchronous to ref_clk_i; shift clock well under 1/6 ref rate
// Notes: outputs are on-levels; the pad inverts for the open-drain sink
`timescale 1ns/100ps
`default_nettype none
`include "dcp_defines.svh"

// Overview of operation
// - shift data on shift clock rising edge
// - sync input treated low after reset
// - only sync rising edge starts capture
// - only synced device accepts bytes
// - new duties applied once eight latches full
// - forward sync after eight latches load
// - enable high: outputs follow pwm values
// - enable low: all outputs off
// - 256 duty levels per channel
// - pwm timed from internal 5 MHz tick
// - minimum on-pulse 120 ns step (code steps in one pwm tick, 200 ns at 5 MHz)
// - data output buffers data input
// - clock output buffers clock input
// - enable output buffers enable input
// - reset forces all outputs on
// - msb first, channel 0 first
module dcp_driver #(
	parameter int CHANNELS = `DCP_CHANNELS,
	parameter int PWM_DIV = `DCP_PWM_DIV
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic serial_data_in_i,
	input wire logic shift_clock_in_i,
	input wire logic sync_chain_in_i,
	input wire logic global_enable_in_i,
	output logic serial_data_out_o,
	output logic shift_clock_out_o,
	output logic sync_chain_out_o,
	output logic global_enable_out_o,
	output logic [CHANNELS-1:0] chan_on_o,
	output dcp_pkg::dcp_state_t state_o
);
	import dcp_pkg::*;

	localparam int CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	localparam int DW = (PWM_DIV > 1) ? $clog2(PWM_DIV) : 1;

	// elaboration guards: settings the counters cannot serve stop the build
	if (CHANNELS < 1 || CHANNELS > 64) begin : g_bad_channels
		$error("CHANNELS out of range");
	end
	if (PWM_DIV < 1) begin : g_bad_div
		$error("PWM_DIV must be at least 1");
	end

	// three-stage synchronisers; stage 0 is read by stage 1 only
	logic [2:0] data_s_r, clk_s_r, sync_s_r, en_s_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			data_s_r <= 3'h0;
			clk_s_r <= 3'h0;
			sync_s_r <= 3'h0;
			en_s_r <= 3'h0;
		end else begin
			data_s_r <= {data_s_r[1:0], serial_data_in_i};
			clk_s_r <= {clk_s_r[1:0], shift_clock_in_i};
			sync_s_r <= {sync_s_r[1:0], sync_chain_in_i};
			en_s_r <= {en_s_r[1:0], global_enable_in_i};
		end
	end

	// a change counts once stages one and two agree
	logic data_f_r, clk_f_r, sync_f_r, en_f_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			data_f_r <= 1'b0;
			clk_f_r <= 1'b0;
			sync_f_r <= 1'b0;
			en_f_r <= 1'b0;
		end else begin
			if (data_s_r[1] == data_s_r[2]) data_f_r <= data_s_r[2];
			if (clk_s_r[1] == clk_s_r[2]) clk_f_r <= clk_s_r[2];
			if (sync_s_r[1] == sync_s_r[2]) sync_f_r <= sync_s_r[2];
			if (en_s_r[1] == en_s_r[2]) en_f_r <= en_s_r[2];
		end
	end

	wire clk_rise = (clk_s_r[1] == clk_s_r[2]) && clk_s_r[2] && !clk_f_r;
	wire sync_rise = (sync_s_r[1] == sync_s_r[2]) && sync_s_r[2] && !sync_f_r;
	wire data_bit = (data_s_r[1] == data_s_r[2]) ? data_s_r[2] : data_f_r;

	// 8-bit shift register, msb arrives first
	logic [7:0] shift_r;
	wire [7:0] shift_nxt = {shift_r[6:0], data_bit};
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) shift_r <= 8'h00;
		else if (clk_rise) shift_r <= shift_nxt;
	end

	// capture control: bit and channel counters
	dcp_state_t state_r;
	logic [2:0] bit_cnt_r;
	logic [CW-1:0] chan_cnt_r;
	wire byte_done = (state_r == DCP_CAPTURE) && clk_rise && (bit_cnt_r == 3'h7);
	wire last_chan = (chan_cnt_r == CW'(CHANNELS - 1));
	wire frame_done = byte_done && last_chan;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_r <= DCP_IDLE;
			bit_cnt_r <= 3'h0;
			chan_cnt_r <= '0;
		end else begin
			unique case (state_r)
				DCP_IDLE: begin
					if (sync_rise) begin
						state_r <= DCP_CAPTURE;
						bit_cnt_r <= 3'h0;
						chan_cnt_r <= '0;
					end
				end
				DCP_CAPTURE: begin
					if (clk_rise) bit_cnt_r <= bit_cnt_r + 3'h1;
					if (byte_done) chan_cnt_r <= chan_cnt_r + CW'(1);
					if (frame_done) state_r <= DCP_IDLE;
				end
			endcase
		end
	end

	// per-channel latches; only a synced device writes them
	// registers live per generate scope, so each has exactly one driver
	wire [7:0] latch_r [CHANNELS];
	wire [7:0] duty_r [CHANNELS];
	generate
		for (genvar g = 0; g < CHANNELS; g++) begin : g_latch
			logic [7:0] held_r;
			logic [7:0] live_r;
			wire hit = byte_done && (chan_cnt_r == CW'(g));
			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) held_r <= 8'hFF;
				else if (hit) held_r <= shift_nxt;
			end
			// duties move together only when all latches are full
			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) live_r <= 8'hFF;
				else if (frame_done) live_r <= (g == CHANNELS - 1) ? shift_nxt : held_r;
			end
			assign latch_r[g] = held_r;
			assign duty_r[g] = live_r;
		end
	endgenerate

	// pwm tick divider: one-cycle enable at the internal pwm rate
	logic [DW-1:0] div_r;
	wire tick = (div_r == DW'(PWM_DIV - 1));
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) div_r <= '0;
		else div_r <= tick ? '0 : div_r + DW'(1);
	end

	// 256-tick period; one tick is the smallest on-pulse step
	logic [7:0] phase_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) phase_r <= 8'h00;
		else if (tick) phase_r <= phase_r + 8'h01;
	end

	// reset forcing: outputs held on while reset is active
	logic por_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) por_r <= 1'b1;
		else por_r <= 1'b0;
	end

	logic [CHANNELS-1:0] on_nxt;
	generate
		for (genvar g = 0; g < CHANNELS; g++) begin : g_cmp
			assign on_nxt[g] = en_f_r && (phase_r < duty_r[g]);
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) chan_on_o <= {CHANNELS{1'b1}};
		else chan_on_o <= on_nxt;
	end

	// sync out rises after the last latch loads, follows input low again
	logic sent_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) sent_r <= 1'b0;
		else if (frame_done) sent_r <= 1'b1;
		else if (sync_rise) sent_r <= 1'b0;
		else if (!sync_f_r) sent_r <= 1'b0;
	end

	// buffered copies; sync path adds latency, acceptable at link rates
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			serial_data_out_o <= 1'b0;
			shift_clock_out_o <= 1'b0;
			global_enable_out_o <= 1'b0;
			sync_chain_out_o <= 1'b0;
			state_o <= DCP_IDLE;
		end else begin
			serial_data_out_o <= data_f_r;
			shift_clock_out_o <= clk_f_r;
			global_enable_out_o <= en_f_r;
			sync_chain_out_o <= sent_r && sync_f_r;
			state_o <= state_r;
		end
	end

	// assertions
	sequence s_last_bit;
		frame_done;
	endsequence
	property p_sync_fwd;
		@(posedge ref_clk_i) disable iff (!rst_n_i) s_last_bit ##1 sync_f_r |=> sync_chain_out_o;
	endproperty
	a_sync_fwd: assert property (p_sync_fwd) else $error("sync not forwarded");
	property p_sync_low;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (state_r == DCP_CAPTURE) |=> !sync_chain_out_o;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("sync out early");
	property p_start;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (state_r == DCP_IDLE && !sync_rise) |=> state_r == DCP_IDLE;
	endproperty
	a_start: assert property (p_start) else $error("capture without sync edge");
	property p_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !en_f_r |=> chan_on_o == '0;
	endproperty
	a_off: assert property (p_off) else $error("output on while disabled");
	property p_zero;
		@(posedge ref_clk_i) disable iff (!rst_n_i) duty_r[0] == 8'h00 |=> !chan_on_o[0];
	endproperty
	a_zero: assert property (p_zero) else $error("zero duty lit");
	property p_on;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (en_f_r && phase_r < duty_r[0]) |=> chan_on_o[0];
	endproperty
	a_on: assert property (p_on) else $error("channel not on");
	property p_data_buf;
		@(posedge ref_clk_i) disable iff (!rst_n_i) $changed(data_f_r) |=> serial_data_out_o == $past(data_f_r);
	endproperty
	a_data_buf: assert property (p_data_buf) else $error("data buffer wrong");
	property p_tick;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (PWM_DIV > 1) && tick |=> !tick;
	endproperty
	a_tick: assert property (p_tick) else $error("pwm tick too fast");
	property p_hold;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (state_r == DCP_IDLE) |=> $stable(latch_r[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("latch written unsynced");
	// entry to capture starts a fresh bit count
	sequence s_sync_edge;
		(state_r == DCP_IDLE) && sync_rise;
	endsequence
	property p_capture;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			s_sync_edge |=> (state_r == DCP_CAPTURE) && (bit_cnt_r == 3'h0);
	endproperty
	a_capture: assert property (p_capture) else $error("capture not armed");
	// one bit per detected shift clock rise, newest bit at the bottom
	property p_shift;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			clk_rise |=> (shift_r[0] == $past(data_bit)) && (shift_r[7:1] == $past(shift_r[6:0]));
	endproperty
	a_shift: assert property (p_shift) else $error("shift step wrong");
	// first byte of a frame lands in channel 0
	property p_first_byte;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			(byte_done && chan_cnt_r == '0) |=> latch_r[0] == $past(shift_nxt);
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("first byte misplaced");
	// duties must not move part way through a frame
	property p_duty_hold;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !frame_done |=> $stable(duty_r[0]);
	endproperty
	a_duty_hold: assert property (p_duty_hold) else $error("duty moved mid frame");
	// first cycle out of reset still shows every output on
	property p_por;
		@(posedge ref_clk_i) disable iff (!rst_n_i) por_r |-> chan_on_o == {CHANNELS{1'b1}};
	endproperty
	a_por: assert property (p_por) else $error("outputs not forced on");
	// buffered clock follows its filtered input one cycle later
	property p_clk_buf;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			$changed(clk_f_r) |=> shift_clock_out_o == $past(clk_f_r);
	endproperty
	a_clk_buf: assert property (p_clk_buf) else $error("clock buffer wrong");
	// buffered enable follows its filtered input one cycle later
	property p_en_buf;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			$changed(en_f_r) |=> global_enable_out_o == $past(en_f_r);
	endproperty
	a_en_buf: assert property (p_en_buf) else $error("enable buffer wrong");
	// a low sync input always pulls the forwarded sync low
	property p_sync_clear;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !sync_f_r |=> !sync_chain_out_o;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync out stuck high");
	// phase steps once per tick and wraps after 256 ticks
	property p_phase;
		@(posedge ref_clk_i) disable iff (!rst_n_i) tick |=> phase_r == $past(phase_r) + 8'h01;
	endproperty
	a_phase: assert property (p_phase) else $error("pwm phase step wrong");
endmodule // dcp_driver
`default_nettype wire

// ### dcp_pkg.sv
// Purpose: types for the chained pwm sink driver
// Assumes: nothing
// Notes: capture state machine states
`default_nettype none
package dcp_pkg;
	typedef enum logic [0:0] {
		DCP_IDLE,
		DCP_CAPTURE
	} dcp_state_t;
endpackage
`default_nettype wire
